// File: socc_pkg.sv
package socc_pkg;

	// Bus clock, also the always-on clock for the waits
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int ADDR_W = 12;
	localparam int TMR_W = 24;

	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_PULSE_STRETCH = 8'h75;
	localparam logic [7:0] IDX_LOOP_FILTER = 8'h76;
	localparam logic [7:0] IDX_CAL_WAIT = 8'h77;
	localparam logic [7:0] IDX_CAL_DELAY = 8'h78;
	localparam logic [7:0] IDX_CAL_STATUS = 8'h79;
	localparam logic [7:0] IDX_CAL_COMMAND = 8'h7a;

	// Field positions
	localparam int STRETCH_BIT = 7;
	localparam int FILT_LSB = 0;
	localparam int FILT_W = 3;
	localparam int CLSD_LSB = 2;
	localparam int OSCW_LSB = 0;
	localparam int DELAY_EN_BIT = 0;
	localparam int CMD_START_BIT = 0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_PHASE_LSB = 1;
	localparam int STAT_DONE_BIT = 3;

	// Reset values
	localparam logic [7:0] RST_PULSE_STRETCH = 8'h00;
	localparam logic [7:0] RST_LOOP_FILTER = 8'h03;
	localparam logic [7:0] RST_CAL_WAIT = 8'h01;
	localparam logic [7:0] RST_CAL_DELAY = 8'h00;

	// Writable bit masks; reserved bits read zero
	localparam logic [7:0] MASK_PULSE_STRETCH = 8'h80;
	localparam logic [7:0] MASK_LOOP_FILTER = 8'h07;
	localparam logic [7:0] MASK_CAL_WAIT = 8'h0f;
	localparam logic [7:0] MASK_CAL_DELAY = 8'h01;

	// Filter order codes
	localparam logic [2:0] FILT_SECOND_ORDER = 3'h3;
	localparam logic [2:0] FILT_THIRD_ORDER = 3'h7;

	// Stabilisation and delay times, as printed
	localparam longint OSC_WAIT0_US = 20;
	localparam longint OSC_WAIT1_US = 400;
	localparam longint OSC_WAIT2_MS = 8;
	localparam longint OSC_WAIT3_MS = 200;
	localparam longint CLSD_WAIT0_US = 30;
	localparam longint CLSD_WAIT1_US = 300;
	localparam longint CLSD_WAIT2_MS = 30;
	localparam longint CLSD_WAIT3_MS = 300;
	localparam longint CAL_DELAY_MS = 60;

	// Least time to cycles, rounded up, never below one
	function automatic longint socc_cycles_up(input longint t_ns);
		longint c;
		c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	// Short counts stay here; long ones are top parameters
	localparam logic [TMR_W-1:0] OSC_WAIT0_CYC = TMR_W'(socc_cycles_up(OSC_WAIT0_US * 1000));
	localparam logic [TMR_W-1:0] CLSD_WAIT0_CYC = TMR_W'(socc_cycles_up(CLSD_WAIT0_US * 1000));

	// Register select codes
	localparam logic [2:0] SEL_STRETCH = 3'h0;
	localparam logic [2:0] SEL_FILTER = 3'h1;
	localparam logic [2:0] SEL_WAIT = 3'h2;
	localparam logic [2:0] SEL_DELAY = 3'h3;
	localparam logic [2:0] SEL_STATUS = 3'h4;
	localparam logic [2:0] SEL_COMMAND = 3'h5;
	localparam logic [2:0] SEL_NONE = 3'h7;

	// Calibration sequence phases
	typedef enum logic [1:0] {SOCC_IDLE, SOCC_DELAY, SOCC_OSC, SOCC_CLOSED} socc_phase_t;

	// Byte address to register select
	function automatic logic [2:0] socc_decode(input logic [ADDR_W-1:0] a);
		if (a == ADDR_W'({IDX_PULSE_STRETCH, 2'b00}))
			return SEL_STRETCH;
		else if (a == ADDR_W'({IDX_LOOP_FILTER, 2'b00}))
			return SEL_FILTER;
		else if (a == ADDR_W'({IDX_CAL_WAIT, 2'b00}))
			return SEL_WAIT;
		else if (a == ADDR_W'({IDX_CAL_DELAY, 2'b00}))
			return SEL_DELAY;
		else if (a == ADDR_W'({IDX_CAL_STATUS, 2'b00}))
			return SEL_STATUS;
		else if (a == ADDR_W'({IDX_CAL_COMMAND, 2'b00}))
			return SEL_COMMAND;
		else
			return SEL_NONE;
	endfunction

endpackage

// File: socc_wait_timer.sv
`timescale 1ns/100ps
module socc_wait_timer
	import socc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic load,
	input wire logic [TMR_W-1:0] load_val,
	output logic expired
);

	// Whole timer state
	typedef struct packed {
		logic [TMR_W-1:0] cnt; // Cycles left, zero when idle
		logic expired; // One-cycle end pulse
	} socc_tmr_state_t;

	socc_tmr_state_t st_r; // Registered state
	socc_tmr_state_t st_nxt; // Next state

	// Count down; a load always restarts, even mid-count
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.expired = 1'b0;
		if (load)
		begin
			st_nxt.cnt = load_val;
		end
		else if (st_r.cnt == TMR_W'(1))
		begin
			// Last cycle of the wait
			st_nxt.cnt = '0;
			st_nxt.expired = 1'b1;
		end
		else if (st_r.cnt != '0)
		begin
			st_nxt.cnt = st_r.cnt - TMR_W'(1);
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign expired = st_r.expired;

endmodule

// File: socc_top.sv
// Notes on behaviour
// - Stretch bit clear: narrow 200 ps pump pulse
// - Stretch bit set: pump pulse about 600 ps
// - Filter code 0x3, reset value: second order
// - Filter code 0x7 selects third-order filter
// - Closed-loop wait code: 30us/300us/30ms/300ms
// - Oscillator wait code: 20us/400us/8ms/200ms, reset 1
// - Delay enable postpones oscillator calibration 60 ms
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
module socc_top
	import socc_pkg::*;
#(
	parameter logic [TMR_W-1:0] OSC_WAIT1_CYC = TMR_W'(socc_cycles_up(OSC_WAIT1_US * 1000)),
	parameter logic [TMR_W-1:0] OSC_WAIT2_CYC = TMR_W'(socc_cycles_up(OSC_WAIT2_MS * 1000000)),
	parameter logic [TMR_W-1:0] OSC_WAIT3_CYC = TMR_W'(socc_cycles_up(OSC_WAIT3_MS * 1000000)),
	parameter logic [TMR_W-1:0] CLSD_WAIT1_CYC = TMR_W'(socc_cycles_up(CLSD_WAIT1_US * 1000)),
	parameter logic [TMR_W-1:0] CLSD_WAIT2_CYC = TMR_W'(socc_cycles_up(CLSD_WAIT2_MS * 1000000)),
	parameter logic [TMR_W-1:0] CLSD_WAIT3_CYC = TMR_W'(socc_cycles_up(CLSD_WAIT3_MS * 1000000)),
	parameter logic [TMR_W-1:0] CAL_DELAY_CYC = TMR_W'(socc_cycles_up(CAL_DELAY_MS * 1000000))
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cal_start,
	output logic synth_one_pulse_stretch,
	output logic [FILT_W-1:0] synth_one_filter_order,
	output logic [1:0] cal_phase,
	output logic cal_busy,
	output logic cal_done
);

	// Whole block state in one word
	typedef struct packed {
		logic [7:0] pulse_stretch_ctrl; // Pump width control
		logic [7:0] loop_filter_ctrl; // Filter order
		logic [7:0] cal_wait_ctrl; // Oscillator and closed-loop waits
		logic [7:0] cal_delay_ctrl; // Calibration postpone enable
		socc_phase_t phase; // Sequence phase
		logic busy; // Sequence running
		logic done_flag; // Sticky completion
		logic done_pulse; // One-cycle completion
		logic [31:0] prdata; // Read data held for the access
		logic pready; // Access phase ready
		logic pslverr; // Unmapped address answer
	} socc_state_t;

	socc_state_t st_r; // Registered state
	socc_state_t st_nxt; // Next state
	logic tmr_load; // Restart the wait timer
	logic [TMR_W-1:0] tmr_val; // Cycles for the new wait
	logic tmr_expired; // Current wait finished
	logic [2:0] sel; // Decoded register
	logic sw_start; // Start written by software
	logic start; // Any start request

	// Oscillator stabilisation wait per code
	function automatic logic [TMR_W-1:0] osc_wait_cycles(input logic [1:0] code);
		case (code)
			2'h0: return OSC_WAIT0_CYC;
			2'h1: return OSC_WAIT1_CYC;
			2'h2: return OSC_WAIT2_CYC;
			default: return OSC_WAIT3_CYC;
		endcase
	endfunction

	// Closed-loop stabilisation wait per code
	function automatic logic [TMR_W-1:0] closed_wait_cycles(input logic [1:0] code);
		case (code)
			2'h0: return CLSD_WAIT0_CYC;
			2'h1: return CLSD_WAIT1_CYC;
			2'h2: return CLSD_WAIT2_CYC;
			default: return CLSD_WAIT3_CYC;
		endcase
	endfunction

	// One shared timer; phases never overlap
	socc_wait_timer u_wait_timer (
		.pclk(pclk),
		.presetn(presetn),
		.load(tmr_load),
		.load_val(tmr_val),
		.expired(tmr_expired)
	);

	// Bus slave, register file and calibration sequencer
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.done_pulse = 1'b0;
		tmr_load = 1'b0;
		tmr_val = '0;
		sw_start = 1'b0;
		sel = socc_decode(paddr);

		if (psel && !penable)
		begin
			// Setup phase: decode and prepare the answer
			st_nxt.pready = 1'b1;
			st_nxt.pslverr = (sel == SEL_NONE);
			st_nxt.prdata = '0;
			if (!pwrite)
			begin
				if (sel == SEL_STRETCH)
					st_nxt.prdata[7:0] = st_r.pulse_stretch_ctrl;
				else if (sel == SEL_FILTER)
					st_nxt.prdata[7:0] = st_r.loop_filter_ctrl;
				else if (sel == SEL_WAIT)
					st_nxt.prdata[7:0] = st_r.cal_wait_ctrl;
				else if (sel == SEL_DELAY)
					st_nxt.prdata[7:0] = st_r.cal_delay_ctrl;
				else if (sel == SEL_STATUS)
				begin
					st_nxt.prdata[STAT_BUSY_BIT] = st_r.busy;
					st_nxt.prdata[STAT_PHASE_LSB +: 2] = st_r.phase;
					st_nxt.prdata[STAT_DONE_BIT] = st_r.done_flag;
				end
			end
		end
		else
		begin
			// Access completes at this edge or no transfer
			st_nxt.pready = 1'b0;
			st_nxt.pslverr = 1'b0;
			if (psel && penable && st_r.pready && pwrite)
			begin
				// Reserved bits are dropped, not stored
				if (sel == SEL_STRETCH)
					st_nxt.pulse_stretch_ctrl = pwdata[7:0] & MASK_PULSE_STRETCH;
				else if (sel == SEL_FILTER)
					st_nxt.loop_filter_ctrl = pwdata[7:0] & MASK_LOOP_FILTER;
				else if (sel == SEL_WAIT)
					st_nxt.cal_wait_ctrl = pwdata[7:0] & MASK_CAL_WAIT;
				else if (sel == SEL_DELAY)
					st_nxt.cal_delay_ctrl = pwdata[7:0] & MASK_CAL_DELAY;
				else if (sel == SEL_COMMAND)
					sw_start = pwdata[CMD_START_BIT];
			end
		end

		start = cal_start | sw_start;

		if (start)
		begin
			st_nxt.done_flag = 1'b0;
			tmr_load = 1'b1;
			if (st_r.cal_delay_ctrl[DELAY_EN_BIT])
			begin
				st_nxt.phase = SOCC_DELAY;
				tmr_val = CAL_DELAY_CYC;
			end
			else
			begin
				st_nxt.phase = SOCC_OSC;
				tmr_val = osc_wait_cycles(st_r.cal_wait_ctrl[OSCW_LSB +: 2]);
			end
		end
		else
		begin
			case (st_r.phase)
				SOCC_DELAY:
				begin
					// Delay over, now the oscillator wait
					if (tmr_expired)
					begin
						st_nxt.phase = SOCC_OSC;
						tmr_load = 1'b1;
						tmr_val = osc_wait_cycles(st_r.cal_wait_ctrl[OSCW_LSB +: 2]);
					end
				end
				SOCC_OSC:
				begin
					// Oscillator settled, close the loop
					if (tmr_expired)
					begin
						st_nxt.phase = SOCC_CLOSED;
						tmr_load = 1'b1;
						tmr_val = closed_wait_cycles(st_r.cal_wait_ctrl[CLSD_LSB +: 2]);
					end
				end
				SOCC_CLOSED:
				begin
					// Loop settled, sequence complete
					if (tmr_expired)
					begin
						st_nxt.phase = SOCC_IDLE;
						st_nxt.done_flag = 1'b1;
						st_nxt.done_pulse = 1'b1;
					end
				end
				default:
				begin
					// Idle until the next start
					st_nxt.phase = SOCC_IDLE;
				end
			endcase
		end

		// Busy follows the phase so it can leave a flop
		st_nxt.busy = (st_nxt.phase != SOCC_IDLE);
	end

	// State register; reset gives documented values
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_r <= '0;
			st_r.pulse_stretch_ctrl <= RST_PULSE_STRETCH;
			st_r.loop_filter_ctrl <= RST_LOOP_FILTER;
			st_r.cal_wait_ctrl <= RST_CAL_WAIT;
			st_r.cal_delay_ctrl <= RST_CAL_DELAY;
			st_r.phase <= SOCC_IDLE;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state flops
	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	// pump width select, high means wide
	assign synth_one_pulse_stretch = st_r.pulse_stretch_ctrl[STRETCH_BIT];
	// code passed to the loop filter
	assign synth_one_filter_order = st_r.loop_filter_ctrl[FILT_LSB +: FILT_W];
	assign cal_phase = st_r.phase;
	assign cal_busy = st_r.busy;
	assign cal_done = st_r.done_pulse;

endmodule

// File: socc_chk_assertions.sv
`timescale 1ns/100ps
// Watches only the top ports of the calibration block
module socc_chk
	import socc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cal_start,
	input wire logic synth_one_pulse_stretch,
	input wire logic [FILT_W-1:0] synth_one_filter_order,
	input wire logic [1:0] cal_phase,
	input wire logic cal_busy,
	input wire logic cal_done
);
	// Completing write edge
	logic wr_done;
	assign wr_done = psel && penable && pready && pwrite;
	// One domain, so one clock and one reset for all
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Slave answers once per access
	ready_one_cycle_a: assert property (pready |=> !pready)
		else $error("pready held over two cycles");
	ready_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	err_read_zero_a: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
		else $error("error without ready or data");
	stretch_write_a: assert property (wr_done && paddr == {2'h0, IDX_PULSE_STRETCH, 2'h0} |=>
		synth_one_pulse_stretch == $past(pwdata[7])) else $error("stretch output wrong");
	filter_write_a: assert property (wr_done && paddr == {2'h0, IDX_LOOP_FILTER, 2'h0} |=>
		synth_one_filter_order == $past(pwdata[2:0])) else $error("filter order wrong");
	busy_phase_a: assert property (cal_busy == (cal_phase != 2'h0))
		else $error("busy differs from phase");
	start_busy_a: assert property (cal_start |=> cal_busy)
		else $error("start did not begin sequence");
	delay_next_a: assert property (cal_phase == 2'h1 |=> cal_phase inside {2'h1, 2'h2})
		else $error("delay phase left wrongly");
	// done only as closed wait ends
	done_end_a: assert property (cal_done |-> $past(cal_phase) == 2'h3 && cal_phase == 2'h0)
		else $error("done outside closed wait end");
endmodule
bind socc_top socc_chk u_chk(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .cal_start(cal_start), .synth_one_pulse_stretch(synth_one_pulse_stretch),
	.synth_one_filter_order(synth_one_filter_order), .cal_phase(cal_phase), .cal_busy(cal_busy),
	.cal_done(cal_done));

// File: test_synth_one_calibration_control.sv
`timescale 1ns/100ps
module test_synth_one_calibration_control
	import socc_pkg::*;
;
	// Bench-driven inputs
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, cal_start = 1'h0;
	logic [ADDR_W-1:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, e, synth_one_pulse_stretch, cal_busy, cal_done;
	logic [FILT_W-1:0] synth_one_filter_order;
	logic [1:0] cal_phase;
	int errors = 0, check_count = 0;
	// Register table: index, reset value, writable mask
	logic [7:0] idx [4] = '{IDX_PULSE_STRETCH, IDX_LOOP_FILTER, IDX_CAL_WAIT, IDX_CAL_DELAY};
	logic [7:0] rst [4] = '{RST_PULSE_STRETCH, RST_LOOP_FILTER, RST_CAL_WAIT, RST_CAL_DELAY};
	logic [7:0] msk [4] = '{MASK_PULSE_STRETCH, MASK_LOOP_FILTER, MASK_CAL_WAIT, MASK_CAL_DELAY};
	// Short counts keep long waits affordable; code 0 and 1 waits run at full length
	socc_top #(.OSC_WAIT2_CYC(24'h14), .OSC_WAIT3_CYC(24'h1e),
		.CLSD_WAIT2_CYC(24'h16), .CLSD_WAIT3_CYC(24'h20),
		.CAL_DELAY_CYC(24'h28)) u_dut(.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cal_start(cal_start),
		.synth_one_pulse_stretch(synth_one_pulse_stretch),
		.synth_one_filter_order(synth_one_filter_order), .cal_phase(cal_phase),
		.cal_busy(cal_busy), .cal_done(cal_done));
	// 20 MHz clock
	initial
	forever
		#25 pclk = ~pclk;
	// Value compare
	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		check_count++;
		if (g !== x)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, x, g);
		end
	endtask
	// APB cycle; waits on pready, only the watchdog ends a hang
	task apb(input logic w, input logic [7:0] i, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {2'h0, i, 2'h0};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// Start pulse of one cycle
	task pulse;
		@(posedge pclk);
		cal_start <= 1'h1;
		@(posedge pclk);
		cal_start <= 1'h0;
	endtask
	// Reset values of all four registers
	task t_reset;
		for (int r = 0; r < 4; r++)
		begin
			apb(1'h0, idx[r], 32'h0);
			chk("reset value", {24'h0, rst[r]}, q);
		end
		chk("filter out", 32'h3, {29'h0, synth_one_filter_order});
		$display("TB: reset test done");
	endtask
	// All ones then all zeros; reserved bits stay zero
	task t_regs;
		logic [7:0] d;
		logic [7:0] v;
		for (int p = 0; p < 2; p++)
		begin
			d = p ? 8'h00 : 8'hff;
			for (int r = 0; r < 4; r++)
			begin
				// Filter code kept to the two legal orders, reserved ones never written
				v = (r == 1) ? (d | 8'h03) : d;
				apb(1'h1, idx[r], {24'h0, v});
				apb(1'h0, idx[r], 32'h0);
				chk("readback", {24'h0, v & msk[r]}, q);
			end
			chk("stretch out", {31'h0, d[7]}, {31'h0, synth_one_pulse_stretch});
			chk("filter out", {29'h0, d[2:0] | 3'h3}, {29'h0, synth_one_filter_order});
		end
		apb(1'h1, IDX_LOOP_FILTER, {29'h0, FILT_THIRD_ORDER});
		// Output settles after the completing edge
		#1;
		chk("filter out", {29'h0, FILT_THIRD_ORDER}, {29'h0, synth_one_filter_order});
		$display("TB: register test done");
	endtask
	// Unmapped place gives error, reads zero
	task t_bad;
		apb(1'h1, 8'h7b, 32'hff);
		chk("write error", 32'h1, {31'h0, e});
		apb(1'h0, 8'h7b, 32'h0);
		chk("read error", 32'h1, {31'h0, e});
		chk("read data", 32'h0, q);
		$display("TB: unmapped test done");
	endtask
	// Calibration run; bench start also restarts once mid-wait
	task t_cal(input logic [7:0] w, input logic dly, input logic cmd, input int ed, eo, ec);
		int n [4];
		n = '{0, 0, 0, 0};
		apb(1'h1, IDX_CAL_WAIT, {24'h0, w});
		apb(1'h1, IDX_CAL_DELAY, {31'h0, dly});
		if (cmd)
			apb(1'h1, IDX_CAL_COMMAND, 32'h1);
		else
		begin
			pulse;
			repeat (3) @(posedge pclk);
			pulse;
		end
		for (int k = 0; k < 20000; k++)
		begin
			#1;
			if (cal_phase === 2'h0)
				break;
			n[cal_phase]++;
			@(posedge pclk);
		end
		chk("done pulse", 32'h1, {31'h0, cal_done});
		chk("busy end", 32'h0, {31'h0, cal_busy});
		chk("delay cycles", ed, n[1]);
		chk("osc cycles", eo, n[2]);
		chk("closed cycles", ec, n[3]);
		apb(1'h0, IDX_CAL_STATUS, 32'h0);
		chk("status", 32'h8, q);
		$display("TB: calibration run done");
	endtask
	// Closing report and verdict
	task give_verdict;
		$display("TB: %0d checks, %0d errors", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Hang guard, far beyond the run length
	initial
	begin
		repeat (40000) @(posedge pclk);
		errors++;
		give_verdict;
	end
	// Main sequence; every wait code once
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		t_reset;
		t_regs;
		t_bad;
		t_cal(8'h05, 1'h0, 1'h0, 0, 8001, 6001);
		t_cal(8'h0e, 1'h1, 1'h1, 41, 21, 33);
		t_cal(8'h0b, 1'h0, 1'h0, 0, 31, 23);
		t_cal(8'h00, 1'h0, 1'h1, 0, 401, 601);
		give_verdict;
	end
endmodule
